// file: design/iswc_defs.svh
`ifndef ISWC_DEFS_SVH
`define ISWC_DEFS_SVH

// ----------------------------------------
// bus addressing
// ----------------------------------------
`define ISWC_ADDR_WR 8'h68
`define ISWC_ADDR_RD 8'h69
`define ISWC_ADDR_MASK 8'hfe
`define ISWC_RW_BIT 0

// ----------------------------------------
// timing, system clock period in ns
// ----------------------------------------
`define ISWC_CLK_NS 100
`define ISWC_WAKE_HOLD_NS 100000
`define ISWC_WAKE_HOLD_CYC ((`ISWC_WAKE_HOLD_NS) / (`ISWC_CLK_NS))
`define ISWC_PROBE_NS 50000
`define ISWC_PROBE_CYC (((`ISWC_PROBE_NS) + (`ISWC_CLK_NS) - 1) / (`ISWC_CLK_NS))

// ----------------------------------------
// reset values
// ----------------------------------------
`define ISWC_BYTE_RST 8'h00

`endif

// file: design/iswc_pkg.sv
package iswc_pkg;

   // ----------------------------------------
   // bus slave sequencer states
   // ----------------------------------------
   typedef enum logic [3:0] {
      ISWC_I2C_IDLE  = 4'b0000,
      ISWC_I2C_ADDR  = 4'b0001,
      ISWC_I2C_AACK  = 4'b0010,
      ISWC_I2C_INDEX = 4'b0011,
      ISWC_I2C_IACK  = 4'b0100,
      ISWC_I2C_WDATA = 4'b0101,
      ISWC_I2C_WACK  = 4'b0110,
      ISWC_I2C_RDATA = 4'b0111,
      ISWC_I2C_RACK  = 4'b1000
   } iswc_i2c_e;

   // ----------------------------------------
   // power states
   // ----------------------------------------
   typedef enum logic [1:0] {
      ISWC_PW_ACTIVE = 2'b00,
      ISWC_PW_SLEEP  = 2'b01,
      ISWC_PW_PROBE  = 2'b10
   } iswc_pw_e;

   // register write port seen by the rest of the chip
   typedef struct packed {
      logic valid;
      logic [7:0] index;
      logic [7:0] data;
   } iswc_wr_s;

endpackage

// file: design/iswc_regmem.sv
`timescale 1ns/100ps

// ----------------------------------------
// register array, registered read data
// ----------------------------------------
module iswc_regmem #(
   parameter int AW = 8
) (
   input wire logic clock,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [7:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [7:0] rdata
);
   logic [7:0] mem [0:(1<<AW)-1];

   // read is registered so the slave always sees a stable byte
   always_ff @(posedge clock) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule // iswc_regmem

// file: design/iswc_top.sv
`timescale 1ns/100ps
`include "iswc_defs.svh"

// What this block does
// RQ1: the master makes every bus clock pulse; we never drive the clock in a transfer.
// RQ2: answer only address byte 0x68 for write and 0x69 for read.
// RQ3: whoever is not sending leaves the data line released high.
// RQ4: pull data low in the acknowledge slot after every byte written to us.
// RQ5: finish a read cleanly whether the master acks or nacks the last byte; only a nack ends the read here, an ack loads and sends the next byte.
// RQ6: master opens each transaction with start and closes it with stop.
// RQ7: order is device address, register index, then one or more data bytes.
// RQ8: successive written bytes go to successive register indexes.
// RQ9: work at every bus rate up to 400 kbit/s.
// RQ10: in very-low-power state turn off radio and host clock output.
// RQ11: keep RC oscillator and wake divider running while asleep.
// RQ12: in polling mode wake the receiver periodically to look for RF energy.
// RQ13: on RF energy enter receive mode and signal the host on both lines.
// RQ14: a programmable service timer also wakes the device.
// RQ15: on service timer expiry signal the host on both lines.
// RQ16: hold all logic in reset while power-on or brownout is asserted.
// RQ17: the host may wake the device by pulling the bus clock low.
// RQ18: after wake, data high means RF energy, data low means service timer.
// RQ19: no clock stretching, no general call, no ten-bit addressing.
// RQ20: reads return the indexed register and advance the index per byte.
module iswc_top import iswc_pkg::*; #(
   parameter int REG_AW = 8,
   parameter int TIMER_W = 24
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic por_brownout,
   input wire logic two_wire_clock_pin_in,
   output logic two_wire_clock_pin_out,
   output logic two_wire_clock_pin_oe,
   input wire logic two_wire_data_pin_in,
   output logic two_wire_data_pin_out,
   output logic two_wire_data_pin_oe,
   input wire logic sleep_req,
   input wire logic poll_enable,
   input wire logic [TIMER_W-1:0] poll_interval,
   input wire logic service_enable,
   input wire logic [TIMER_W-1:0] service_interval,
   input wire logic rf_energy,
   output logic radio_enable,
   output logic host_clock_output_enable,
   output logic rc_osc_run,
   output logic wake_divider_run,
   output logic rx_mode,
   output iswc_wr_s reg_write
);
   localparam logic [11:0] HOLD_CYC = 12'(`ISWC_WAKE_HOLD_CYC);
   localparam logic [11:0] PROBE_CYC = 12'(`ISWC_PROBE_CYC);

   // refuse widths that the array and the wake counters cannot serve
   if (REG_AW < 1 || REG_AW > 8) begin : g_bad_reg_aw
      $error("REG_AW must be 1..8");
   end
   if (TIMER_W < 2 || TIMER_W > 32) begin : g_bad_timer_w
      $error("TIMER_W must be 2..32");
   end

   // ----------------------------------------
   // reset and input synchronisers
   // ----------------------------------------
   logic por_meta_reg, por_sync_reg, srst;
   logic scl_meta_reg, scl_s_reg, scl_d_reg, sda_meta_reg, sda_s_reg, sda_d_reg, rf_meta_reg, rf_s_reg;

   // por is caught without reset since it is itself the reset source
   always_ff @(posedge clock) begin
      por_meta_reg <= por_brownout;
      por_sync_reg <= por_meta_reg;
   end
   assign srst = rst | por_sync_reg; // [RQ16]

   // pins idle high; edges come only from the second and third stages
   always_ff @(posedge clock) begin
      if (srst) begin
         {scl_meta_reg, scl_s_reg, scl_d_reg} <= 3'h7;
         {sda_meta_reg, sda_s_reg, sda_d_reg} <= 3'h7;
         {rf_meta_reg, rf_s_reg} <= 2'h0;
      end else begin
         {scl_meta_reg, scl_s_reg, scl_d_reg} <= {two_wire_clock_pin_in, scl_meta_reg, scl_s_reg};
         {sda_meta_reg, sda_s_reg, sda_d_reg} <= {two_wire_data_pin_in, sda_meta_reg, sda_s_reg};
         {rf_meta_reg, rf_s_reg} <= {rf_energy, rf_meta_reg};
      end
   end

   logic scl_rise, scl_fall, start_det, stop_det;
   // 10 MHz sampling leaves >= 12 samples per half period at 400 kbit/s
   assign scl_rise = scl_s_reg & ~scl_d_reg; // [RQ9]
   assign scl_fall = ~scl_s_reg & scl_d_reg;
   assign start_det = scl_s_reg & scl_d_reg & ~sda_s_reg & sda_d_reg; // [RQ6]
   assign stop_det = scl_s_reg & scl_d_reg & sda_s_reg & ~sda_d_reg;

   // ----------------------------------------
   // bus slave sequencer
   // ----------------------------------------
   iswc_i2c_e i2c_reg, i2c_next;
   logic [3:0] bit_reg, bit_next;
   logic [7:0] sh_reg, sh_next, idx_reg, idx_next, rd_data;
   logic drv_reg, drv_next, rw_reg, rw_next;
   iswc_wr_s wr_reg, wr_next;

   // clock edges and line levels drive every step; no stretching exists [RQ19]
   always_comb begin
      i2c_next = i2c_reg;
      bit_next = bit_reg;
      sh_next = sh_reg;
      idx_next = idx_reg;
      drv_next = drv_reg;
      rw_next = rw_reg;
      wr_next = '0;
      if (start_det) begin // repeated start also lands here
         i2c_next = ISWC_I2C_ADDR;
         bit_next = 4'h0;
         drv_next = 1'b0;
      end else if (stop_det) begin
         i2c_next = ISWC_I2C_IDLE;
         drv_next = 1'b0;
      end else if (scl_rise) begin
         unique case (i2c_reg)
            ISWC_I2C_ADDR, ISWC_I2C_INDEX, ISWC_I2C_WDATA: begin
               sh_next = {sh_reg[6:0], sda_s_reg};
               bit_next = bit_reg + 4'h1;
            end
            ISWC_I2C_RACK: sh_next[0] = sda_s_reg; // master ack level, 1 = nack
            default: ;
         endcase
      end else if (scl_fall) begin
         unique case (i2c_reg)
            ISWC_I2C_ADDR: if (bit_reg == 4'h8) begin
               // general call and ten-bit headers fall out as foreign [RQ2] [RQ19]
               if ((sh_reg & `ISWC_ADDR_MASK) == `ISWC_ADDR_WR) begin
                  i2c_next = ISWC_I2C_AACK;
                  drv_next = 1'b1; // [RQ4]
                  rw_next = sh_reg[`ISWC_RW_BIT];
               end else begin
                  i2c_next = ISWC_I2C_IDLE;
               end
            end
            ISWC_I2C_AACK, ISWC_I2C_RACK: begin
               bit_next = 4'h0;
               if (i2c_reg == ISWC_I2C_RACK && sh_reg[0]) begin
                  i2c_next = ISWC_I2C_IDLE; // nack ends the read; wait for stop [RQ5]
                  drv_next = 1'b0;
               end else if (i2c_reg == ISWC_I2C_RACK || rw_reg) begin
                  sh_next = rd_data; // [RQ20]
                  idx_next = idx_reg + 8'h01;
                  drv_next = ~rd_data[7];
                  i2c_next = ISWC_I2C_RDATA;
               end else begin
                  drv_next = 1'b0; // [RQ3]
                  i2c_next = ISWC_I2C_INDEX; // [RQ7]
               end
            end
            ISWC_I2C_INDEX: if (bit_reg == 4'h8) begin
               idx_next = sh_reg;
               drv_next = 1'b1; // [RQ4]
               i2c_next = ISWC_I2C_IACK;
            end
            ISWC_I2C_WDATA: if (bit_reg == 4'h8) begin
               wr_next = '{valid: 1'b1, index: idx_reg, data: sh_reg};
               drv_next = 1'b1; // [RQ4]
               i2c_next = ISWC_I2C_WACK;
            end
            ISWC_I2C_IACK, ISWC_I2C_WACK: begin
               if (i2c_reg == ISWC_I2C_WACK) idx_next = idx_reg + 8'h01; // [RQ8]
               bit_next = 4'h0;
               drv_next = 1'b0; // [RQ3]
               i2c_next = ISWC_I2C_WDATA;
            end
            ISWC_I2C_RDATA: begin
               bit_next = bit_reg + 4'h1;
               if (bit_reg == 4'h7) begin
                  drv_next = 1'b0; // release for the master's ack [RQ3]
                  i2c_next = ISWC_I2C_RACK;
               end else begin
                  sh_next = {sh_reg[6:0], 1'b0};
                  drv_next = ~sh_reg[6];
               end
            end
            default: i2c_next = ISWC_I2C_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         i2c_reg <= ISWC_I2C_IDLE;
         bit_reg <= 4'h0;
         sh_reg <= `ISWC_BYTE_RST;
         idx_reg <= `ISWC_BYTE_RST;
         drv_reg <= 1'b0;
         rw_reg <= 1'b0;
         wr_reg <= '0;
      end else begin
         i2c_reg <= i2c_next;
         bit_reg <= bit_next;
         sh_reg <= sh_next;
         idx_reg <= idx_next;
         drv_reg <= drv_next;
         rw_reg <= rw_next;
         wr_reg <= wr_next;
      end
   end

   iswc_regmem #(.AW(REG_AW)) u_mem (
      .clock(clock),
      .we(wr_reg.valid),
      .waddr(wr_reg.index[REG_AW-1:0]),
      .wdata(wr_reg.data),
      .raddr(idx_reg[REG_AW-1:0]),
      .rdata(rd_data)
   );
   assign reg_write = wr_reg;

   // ----------------------------------------
   // power and wake control
   // ----------------------------------------
   iswc_pw_e pw_reg, pw_next;
   logic [TIMER_W-1:0] poll_cnt_reg, poll_cnt_next, svc_cnt_reg, svc_cnt_next;
   logic [11:0] probe_reg, probe_next, hold_reg, hold_next;
   logic show_reg, show_next, cause_rf_reg, cause_rf_next, rx_reg, rx_next;

   // the service timer keeps counting through probes so both sources coexist
   always_comb begin
      pw_next = pw_reg;
      poll_cnt_next = poll_cnt_reg;
      svc_cnt_next = svc_cnt_reg;
      probe_next = probe_reg;
      hold_next = (hold_reg != 12'h0) ? hold_reg - 12'h1 : hold_reg;
      // a held-low cause would block any start, so a host clock fall after our hold also lets go
      show_next = (start_det || (scl_fall && hold_reg == 12'h0)) ? 1'b0 : show_reg; // [RQ3] [RQ18]
      cause_rf_next = cause_rf_reg;
      rx_next = rx_reg;
      unique case (pw_reg)
         ISWC_PW_ACTIVE: if (sleep_req) begin
            pw_next = ISWC_PW_SLEEP; // [RQ10]
            poll_cnt_next = '0;
            svc_cnt_next = '0;
            rx_next = 1'b0;
         end
         ISWC_PW_SLEEP: begin
            svc_cnt_next = svc_cnt_reg + 1'b1;
            poll_cnt_next = poll_cnt_reg + 1'b1;
            if (!scl_s_reg) begin
               pw_next = ISWC_PW_ACTIVE; // host wake, no cause shown [RQ17]
            end else if (service_enable && svc_cnt_reg >= service_interval) begin
               pw_next = ISWC_PW_ACTIVE; // [RQ14]
               show_next = 1'b1; // [RQ15]
               cause_rf_next = 1'b0; // [RQ18]
               hold_next = HOLD_CYC;
            end else if (poll_enable && poll_cnt_reg >= poll_interval) begin
               pw_next = ISWC_PW_PROBE; // [RQ12]
               poll_cnt_next = '0;
               probe_next = 12'h0;
            end
         end
         ISWC_PW_PROBE: begin
            svc_cnt_next = svc_cnt_reg + 1'b1;
            probe_next = probe_reg + 12'h1;
            if (rf_s_reg) begin
               pw_next = ISWC_PW_ACTIVE;
               rx_next = 1'b1; // [RQ13]
               show_next = 1'b1;
               cause_rf_next = 1'b1; // [RQ18]
               hold_next = HOLD_CYC;
            end else if (probe_reg == PROBE_CYC - 12'h1) begin
               pw_next = ISWC_PW_SLEEP;
            end
         end
         default: pw_next = ISWC_PW_ACTIVE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         pw_reg <= ISWC_PW_ACTIVE;
         poll_cnt_reg <= '0;
         svc_cnt_reg <= '0;
         probe_reg <= 12'h0;
         hold_reg <= 12'h0;
         show_reg <= 1'b0;
         cause_rf_reg <= 1'b0;
         rx_reg <= 1'b0;
      end else begin
         pw_reg <= pw_next;
         poll_cnt_reg <= poll_cnt_next;
         svc_cnt_reg <= svc_cnt_next;
         probe_reg <= probe_next;
         hold_reg <= hold_next;
         show_reg <= show_next;
         cause_rf_reg <= cause_rf_next;
         rx_reg <= rx_next;
      end
   end

   // ----------------------------------------
   // pins and power outputs
   // ----------------------------------------
   // open drain: only ever pull low; high comes from the pullups
   assign two_wire_clock_pin_out = 1'b0;
   assign two_wire_data_pin_out = 1'b0;
   assign two_wire_clock_pin_oe = (hold_reg != 12'h0); // wake pulse only, never in a transfer [RQ1] [RQ13]
   assign two_wire_data_pin_oe = drv_reg | (show_reg & ~cause_rf_reg); // [RQ3] [RQ18]
   assign radio_enable = (pw_reg != ISWC_PW_SLEEP); // [RQ10] [RQ12]
   assign host_clock_output_enable = (pw_reg == ISWC_PW_ACTIVE);
   assign rc_osc_run = 1'b1; // [RQ11]
   assign wake_divider_run = 1'b1;
   assign rx_mode = rx_reg;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   property p_addr_ack;
      @(posedge clock) disable iff (srst)
      (scl_fall && !start_det && !stop_det && i2c_reg == ISWC_I2C_ADDR && bit_reg == 4'h8
       && (sh_reg & 8'hfe) == 8'h68) |=> (drv_reg && i2c_reg == ISWC_I2C_AACK);
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged"); // [RQ2]

   property p_foreign;
      @(posedge clock) disable iff (srst)
      (scl_fall && !start_det && !stop_det && i2c_reg == ISWC_I2C_ADDR && bit_reg == 4'h8
       && (sh_reg & 8'hfe) != 8'h68) |=> (i2c_reg == ISWC_I2C_IDLE && !two_wire_data_pin_oe) [*2];
   endproperty
   a_foreign: assert property (p_foreign) else $error("foreign address answered"); // [RQ19]

   property p_data_ack;
      @(posedge clock) disable iff (srst)
      (scl_fall && !start_det && !stop_det && i2c_reg == ISWC_I2C_WDATA && bit_reg == 4'h8)
      |=> (drv_reg && reg_write.valid && reg_write.data == $past(sh_reg));
   endproperty
   a_data_ack: assert property (p_data_ack) else $error("data byte not acked or stored"); // [RQ4]

   property p_release;
      @(posedge clock) disable iff (srst)
      (i2c_reg inside {ISWC_I2C_ADDR, ISWC_I2C_INDEX, ISWC_I2C_WDATA, ISWC_I2C_RACK}) |-> !drv_reg;
   endproperty
   a_release: assert property (p_release) else $error("data line held while master sends"); // [RQ3]

   property p_autoinc;
      @(posedge clock) disable iff (srst)
      (scl_fall && !start_det && !stop_det && i2c_reg == ISWC_I2C_WACK)
      |=> (idx_reg == $past(idx_reg) + 8'h01 && i2c_reg == ISWC_I2C_WDATA);
   endproperty
   a_autoinc: assert property (p_autoinc) else $error("write index not advanced"); // [RQ8]

   property p_read_load;
      @(posedge clock) disable iff (srst)
      (scl_fall && !start_det && !stop_det && i2c_reg == ISWC_I2C_AACK && rw_reg)
      |=> (sh_reg == $past(rd_data) && idx_reg == $past(idx_reg) + 8'h01 && drv_reg == ~sh_reg[7]);
   endproperty
   a_read_load: assert property (p_read_load) else $error("read byte or index wrong"); // [RQ20]

   property p_nack_end;
      @(posedge clock) disable iff (srst)
      (scl_fall && !start_det && !stop_det && i2c_reg == ISWC_I2C_RACK && sh_reg[0])
      |=> (i2c_reg == ISWC_I2C_IDLE && !drv_reg);
   endproperty
   a_nack_end: assert property (p_nack_end) else $error("read not ended on nack"); // [RQ5]

   property p_sleep_off;
      @(posedge clock) disable iff (srst)
      (pw_reg == ISWC_PW_SLEEP) |-> (!radio_enable && !host_clock_output_enable && rc_osc_run && wake_divider_run);
   endproperty
   a_sleep_off: assert property (p_sleep_off) else $error("sleep state power wrong"); // [RQ10]

   property p_probe_on;
      @(posedge clock) disable iff (srst)
      $rose(pw_reg == ISWC_PW_PROBE) |-> (radio_enable && !host_clock_output_enable);
   endproperty
   a_probe_on: assert property (p_probe_on) else $error("receiver not powered in probe"); // [RQ12]

   property p_rf_wake;
      @(posedge clock) disable iff (srst)
      (pw_reg == ISWC_PW_PROBE && rf_s_reg) |=> (pw_reg == ISWC_PW_ACTIVE && rx_mode
       && two_wire_clock_pin_oe && !two_wire_data_pin_oe)[*3];
   endproperty
   a_rf_wake: assert property (p_rf_wake) else $error("rf wake not signalled"); // [RQ13]

   property p_svc_wake;
      @(posedge clock) disable iff (srst)
      (pw_reg == ISWC_PW_SLEEP && scl_s_reg && service_enable && svc_cnt_reg >= service_interval)
      |=> (two_wire_clock_pin_oe && two_wire_data_pin_oe && pw_reg == ISWC_PW_ACTIVE);
   endproperty
   a_svc_wake: assert property (p_svc_wake) else $error("service wake not signalled"); // [RQ15]

   property p_por;
      @(posedge clock) disable iff (rst)
      por_sync_reg |=> (i2c_reg == ISWC_I2C_IDLE && pw_reg == ISWC_PW_ACTIVE && !two_wire_clock_pin_oe);
   endproperty
   a_por: assert property (p_por) else $error("logic not held in reset"); // [RQ16]

   c_write: cover property (@(posedge clock) disable iff (srst) reg_write.valid ##[1:300] reg_write.valid);
   c_read: cover property (@(posedge clock) disable iff (srst) i2c_reg == ISWC_I2C_RACK ##1 i2c_reg == ISWC_I2C_RDATA);
   c_rf: cover property (@(posedge clock) disable iff (srst) pw_reg == ISWC_PW_PROBE ##1 rx_mode);
   c_svc: cover property (@(posedge clock) disable iff (srst) $rose(show_reg) && !cause_rf_reg);
endmodule // iswc_top

// file: testbench/iswc_host_model.sv
`timescale 1ns/100ps

// ----------------------------------------
// two-wire bus master, open-drain drivers
// ----------------------------------------
module iswc_host_model (
   input wire logic scl,
   input wire logic sda,
   output logic scl_low,
   output logic sda_low
);
   localparam int Q = 200; // quarter of the 800 ns bus clock

   // both lines released at time zero, pull-ups hold them high
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end

   // one bit: data moves mid low phase, sampled late in high phase, well after the slave's slow reply
   task automatic bit_io(input logic b, output logic s);
      scl_low = 1'b1;
      #Q sda_low = ~b; // release when sending one or listening
      #Q scl_low = 1'b0;
      #(2*Q-50) s = sda;
      #50;
   endtask

   // start, also usable as repeated start
   task automatic start;
      scl_low = 1'b1;
      #Q sda_low = 1'b0;
      #Q scl_low = 1'b0;
      #(2*Q) sda_low = 1'b1;
      #(2*Q);
   endtask

   // stop ends every transaction
   task automatic stop;
      scl_low = 1'b1;
      #Q sda_low = 1'b1;
      #Q scl_low = 1'b0;
      #(2*Q) sda_low = 1'b0;
      #(2*Q);
   endtask

   // byte out msb first, then listen for the acknowledge
   task automatic put(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], s);
      end
      bit_io(1'b1, s);
      ack = ~s;
   endtask

   // byte in, then ack or nack
   task automatic get(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, s);
         d[i] = s;
      end
      bit_io(last, s);
   endtask

   // wake request by holding the clock line low
   task automatic hold_clock(input int ns);
      scl_low = 1'b1;
      #ns scl_low = 1'b0;
   endtask
endmodule // iswc_host_model

// file: testbench/testbench.sv
`timescale 1ns/100ps

module testbench;
   import iswc_pkg::*;
   logic clock = 1'b0, rst = 1'b1, por_brownout = 1'b0, sleep_req = 1'b0;
   logic poll_enable = 1'b0, service_enable = 1'b0, rf_energy = 1'b0;
   logic [23:0] poll_interval = 24'h000014, service_interval = 24'h000014;
   logic scl_o, scl_oe, sda_o, sda_oe, radio_enable, host_en, rc_run, div_run, rx_mode;
   logic scl_low, sda_low, ack;
   logic [7:0] rd;
   logic [7:0] rows [3][3] = '{'{8'h00, 8'h5a, 8'ha5}, '{8'h7f, 8'h3c, 8'hc3}, '{8'hff, 8'h81, 8'h18}};
   iswc_wr_s reg_write;
   iswc_wr_s wq[$];
   int mismatches = 0, check_count = 0, cycles = 0, scl_pull = 0, n;
   // wired-and of open-drain drivers, pull-ups make a released line high
   wire logic scl = ~(scl_low | (scl_oe & ~scl_o));
   wire logic sda = ~(sda_low | (sda_oe & ~sda_o));

   iswc_top #(.REG_AW(8), .TIMER_W(24)) iswc_top_inst (.clock(clock), .rst(rst), .por_brownout(por_brownout),
      .two_wire_clock_pin_in(scl), .two_wire_clock_pin_out(scl_o), .two_wire_clock_pin_oe(scl_oe),
      .two_wire_data_pin_in(sda), .two_wire_data_pin_out(sda_o), .two_wire_data_pin_oe(sda_oe),
      .sleep_req(sleep_req), .poll_enable(poll_enable), .poll_interval(poll_interval),
      .service_enable(service_enable), .service_interval(service_interval), .rf_energy(rf_energy),
      .radio_enable(radio_enable), .host_clock_output_enable(host_en), .rc_osc_run(rc_run),
      .wake_divider_run(div_run), .rx_mode(rx_mode), .reg_write(reg_write));
   iswc_host_model iswc_host_model_inst (.scl(scl), .sda(sda), .scl_low(scl_low), .sda_low(sda_low));

   always #50 clock = ~clock;

   // write monitor, clock-pull count and hang guard
   always @(posedge clock) begin
      cycles++;
      if (reg_write.valid === 1'b1) wq.push_back(reg_write);
      if (scl_oe === 1'b1) scl_pull++;
      if (cycles == 40000) begin
         mismatches++;
         finish_test();
      end
   end

   task automatic check(input string name, input logic [16:0] seen, input logic [16:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // inputs always change a fixed 10 ns after the edge
   task automatic tick(input int k);
      repeat (k) @(posedge clock);
      #10;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d0, input logic [7:0] d1);
      logic [7:0] b [4];
      b = '{8'h68, idx, d0, d1};
      iswc_host_model_inst.start();
      foreach (b[i]) begin
         iswc_host_model_inst.put(b[i], ack);
         check("write_ack", 17'(ack), 17'h00001);
      end
      iswc_host_model_inst.stop();
   endtask

   // index write, repeated start, two bytes read, nack on the last
   task automatic rdb(input logic [7:0] idx, input logic [7:0] e0, input logic [7:0] e1);
      iswc_host_model_inst.start();
      iswc_host_model_inst.put(8'h68, ack);
      iswc_host_model_inst.put(idx, ack);
      iswc_host_model_inst.start();
      iswc_host_model_inst.put(8'h69, ack);
      check("read_ack", 17'(ack), 17'h00001);
      iswc_host_model_inst.get(1'b0, rd);
      check("read_b0", 17'(rd), 17'(e0));
      iswc_host_model_inst.get(1'b1, rd);
      check("read_b1", 17'(rd), 17'(e1));
      iswc_host_model_inst.stop();
   endtask

   task automatic sleep_now;
      sleep_req = 1'b1;
      tick(1);
      sleep_req = 1'b0;
   endtask

   initial begin
      // reset state
      tick(16);
      check("reset_out", 17'({scl_oe, sda_oe, radio_enable, host_en, rx_mode, reg_write.valid}), 17'h0000c);
      rst = 1'b0;
      tick(2);
      // table rows: index, two data bytes, with index wrap in the last row
      foreach (rows[r]) begin
         wq.delete();
         wr(rows[r][0], rows[r][1], rows[r][2]);
         check("wr_count", 17'(wq.size()), 17'h00002);
         check("wr_0", 17'(wq[0]), {1'b1, rows[r][0], rows[r][1]});
         check("wr_1", 17'(wq[1]), {1'b1, rows[r][0] + 8'h01, rows[r][2]});
         rdb(rows[r][0], rows[r][1], rows[r][2]);
      end
      // foreign, general call and ten-bit prefix addresses are ignored
      wq.delete();
      foreach (rows[r]) begin
         iswc_host_model_inst.start();
         iswc_host_model_inst.put(r == 0 ? 8'h6a : (r == 1 ? 8'h00 : 8'hf0), ack);
         check("foreign_ack", 17'(ack), 17'h00000);
         iswc_host_model_inst.put(8'h55, ack);
         iswc_host_model_inst.stop();
      end
      check("foreign_wr", 17'(wq.size()), 17'h00000);
      check("no_clock_pull", 17'(scl_pull), 17'h00000);
      // sleep, then host wake by clock low
      sleep_now();
      tick(2);
      check("sleep_out", 17'({radio_enable, host_en, rc_run, div_run}), 17'h00003);
      iswc_host_model_inst.hold_clock(1000);
      tick(2);
      check("host_wake", 17'({radio_enable, host_en, scl_oe, sda_oe}), 17'h0000c);
      // service timer wake, cause low on data
      service_enable = 1'b1;
      sleep_now();
      n = 0;
      while (scl_oe !== 1'b1 && n < 200) begin
         tick(1);
         n++;
      end
      check("svc_time", 17'(n >= 18 && n <= 26), 17'h00001);
      check("svc_wake", 17'({radio_enable, host_en, scl_oe, sda_oe, rx_mode}), 17'h0001e);
      service_enable = 1'b0;
      tick(1005);
      check("svc_cause", 17'({scl_oe, sda}), 17'h00000);
      wr(8'h20, 8'h11, 8'h22);
      check("svc_clear", 17'(sda_oe), 17'h00000);
      // polling: one empty probe, then a probe that sees energy
      poll_enable = 1'b1;
      sleep_now();
      n = 0;
      while (radio_enable !== 1'b1 && n < 200) begin
         tick(1);
         n++;
      end
      check("probe", 17'({radio_enable, host_en, n <= 26}), 17'h00005);
      tick(505);
      check("probe_end", 17'(radio_enable), 17'h00000);
      n = 0;
      while (radio_enable !== 1'b1 && n < 200) begin
         tick(1);
         n++;
      end
      rf_energy = 1'b1;
      tick(6);
      rf_energy = 1'b0;
      poll_enable = 1'b0;
      check("rf_wake", 17'({radio_enable, host_en, rx_mode, scl_oe, sda_oe, sda}), 17'h0003d);
      // power-on indication in mid hold forces reset
      por_brownout = 1'b1;
      tick(4);
      check("por_out", 17'({scl_oe, sda_oe, radio_enable, host_en, rx_mode, reg_write.valid}), 17'h0000c);
      por_brownout = 1'b0;
      tick(4);
      wq.delete();
      wr(8'h40, 8'h9e, 8'h61);
      check("por_wr", 17'(wq.size()), 17'h00002);
      rdb(8'h40, 8'h9e, 8'h61);
      finish_test();
   end
endmodule // testbench
